/* common/gst_consts.svh */
// register offsets, field positions and timing constants of the gated timer
`ifndef GST_CONSTS_SVH
`define GST_CONSTS_SVH

// printed offsets, F00 aside, are not multiples of four: they are register indices
`define GST_IDX_GATE_CTRL 12'hF9A
`define GST_IDX_TIMER_CTRL 12'hFCD
`define GST_IDX_COUNT 12'hFCE
`define GST_IDX_INT_STATUS 12'hF00
`define GST_IDX_INT_MASK 12'hF01
`define GST_ADDR_W 14

// timer control fields
`define GST_TC_CS_HI 7
`define GST_TC_CS_LO 6
`define GST_TC_PS_HI 5
`define GST_TC_PS_LO 4
`define GST_TC_OSCEN 3
`define GST_TC_SYNC 2
`define GST_TC_WIDE 1
`define GST_TC_RUN 0

// gate control fields
`define GST_GC_EN 7
`define GST_GC_POL 6
`define GST_GC_TM 5
`define GST_GC_SPM 4
`define GST_GC_GO 3
`define GST_GC_VAL 2
`define GST_GC_SS_HI 1
`define GST_GC_SS_LO 0
`define GST_GC_WMASK 8'hFB

// clock source and gate source codes
`define GST_CS_INSTR 2'h0
`define GST_CS_SYS 2'h1
`define GST_CS_EXT 2'h2
`define GST_GS_PIN 2'h0
`define GST_GS_OVF 2'h1
`define GST_GS_MATCH 2'h2

`define GST_INSTR_DIV 2'h3
`define GST_CTRL_RST 8'h00
`define GST_IRQ_OVF 0
`define GST_IRQ_GATE 1
`define GST_IRQ_W 2

`endif

/* common/gst_pkg.sv */
// types shared by the gated timer modules
package gst_pkg;
   typedef struct packed {
      logic [1:0] clock_source_select;
      logic [1:0] prescale_select;
      logic crystal_osc_enable;
      logic ext_clock_sync_bypass;
      logic wide_access_mode;
      logic timer_run;
   } gst_tctrl_s;

   typedef enum logic [1:0] {
      GST_SP_IDLE = 2'b00,
      GST_SP_WAIT = 2'b01,
      GST_SP_ACQ = 2'b10
   } gst_sp_e;
endpackage

/* common/gst_tick_if.sv */
// count tick handshake between clock selector and timer core
`timescale 1ns/100ps
interface gst_tick_if;
   logic tick;
   logic [1:0] clock_source_select;
   logic [1:0] prescale_select;
   logic ext_clock_sync_bypass;
   logic timer_run;
   modport src (output tick, input clock_source_select, input prescale_select,
      input ext_clock_sync_bypass, input timer_run);
   modport dst (input tick, output clock_source_select,
      output prescale_select, output ext_clock_sync_bypass,
      output timer_run);
endinterface

/* core/gst_clock_select.sv */
// count clock source selection, external sync and prescaler
`timescale 1ns/100ps
`include "gst_consts.svh"
module gst_clock_select
   import gst_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic ext_clk_i,
   gst_tick_if.src tk
);
   typedef struct packed {
      logic [1:0] instr_div;
      logic sync1;
      logic sync2;
      logic ext_prev;
      logic [2:0] pre_cnt;
   } gst_cs_s;

   gst_cs_s st_q;
   gst_cs_s st_d;
   logic raw_tick;
   logic ext_raw;

   always_comb begin
      st_d = st_q;
      st_d.instr_div = st_q.instr_div + 2'h1;
      st_d.sync1 = ext_clk_i;
      st_d.sync2 = st_q.sync1;
      // sync bypass uses the raw pin level, sync path the second stage
      ext_raw = tk.ext_clock_sync_bypass ? ext_clk_i : st_q.sync2;
      st_d.ext_prev = ext_raw;
      unique case (tk.clock_source_select)
         `GST_CS_INSTR: raw_tick = (st_q.instr_div == `GST_INSTR_DIV);
         `GST_CS_SYS: raw_tick = 1'b1;
         `GST_CS_EXT: raw_tick = ext_raw & ~st_q.ext_prev;
         default: raw_tick = 1'b0;
      endcase
      tk.tick = 1'b0;
      if (raw_tick && tk.timer_run) begin
         st_d.pre_cnt = st_q.pre_cnt + 3'h1;
         unique case (tk.prescale_select)
            2'h0: tk.tick = 1'b1;
            2'h1: tk.tick = st_q.pre_cnt[0];
            2'h2: tk.tick = &st_q.pre_cnt[1:0];
            2'h3: tk.tick = &st_q.pre_cnt;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // gst_clock_select

/* core/gst_gate_unit.sv */
// gate source select, polarity, toggle and single pulse logic
`timescale 1ns/100ps
`include "gst_consts.svh"
module gst_gate_unit
   import gst_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [7:0] gctrl_i,
   input wire logic go_set_i,
   input wire logic gate_pin_i,
   input wire logic ovf_i,
   input wire logic match_i,
   output logic gate_open_o,
   output logic gate_level_o,
   output logic go_done_o,
   output logic done_pulse_o
);
   typedef struct packed {
      logic prev;
      logic tgl;
      gst_sp_e sp;
   } gst_gu_s;

   gst_gu_s st_q;
   gst_gu_s st_d;
   logic src;
   logic lvl;
   logic edge_a;
   logic edge_i;

   always_comb begin
      st_d = st_q;
      done_pulse_o = 1'b0;
      unique case (gctrl_i[`GST_GC_SS_HI:`GST_GC_SS_LO])
         `GST_GS_PIN: src = gate_pin_i;
         `GST_GS_OVF: src = ovf_i;
         `GST_GS_MATCH: src = match_i;
         default: src = 1'b0;
      endcase
      lvl = gctrl_i[`GST_GC_POL] ? src : ~src;
      st_d.prev = lvl;
      edge_a = lvl & ~st_q.prev;
      edge_i = ~lvl & st_q.prev;
      if (!gctrl_i[`GST_GC_TM]) begin
         st_d.tgl = 1'b0;
      end else if (edge_a) begin
         st_d.tgl = ~st_q.tgl;
      end
      if (!gctrl_i[`GST_GC_SPM]) begin
         st_d.sp = GST_SP_IDLE;
      end else begin
         unique case (st_q.sp)
            GST_SP_IDLE: if (go_set_i) st_d.sp = GST_SP_WAIT;
            GST_SP_WAIT: if (edge_a) st_d.sp = GST_SP_ACQ;
            GST_SP_ACQ: begin
               if (edge_i || (gctrl_i[`GST_GC_TM] && edge_a)) begin
                  st_d.sp = GST_SP_IDLE;
                  done_pulse_o = 1'b1;
               end
            end
            default: st_d.sp = GST_SP_IDLE;
         endcase
      end
      gate_level_o = gctrl_i[`GST_GC_TM] ? st_q.tgl : lvl;
      if (gctrl_i[`GST_GC_SPM]) begin
         gate_open_o = (st_q.sp == GST_SP_ACQ) &&
            (gctrl_i[`GST_GC_TM] ? st_q.tgl : lvl);
      end else begin
         gate_open_o = gate_level_o;
      end
      go_done_o = (st_q.sp != GST_SP_IDLE);
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // gst_gate_unit

/* core/gst_timer.sv */
// gated sixteen bit timer top: apb registers, counter and interrupt
//
// How it works
// - clock source code picks count clock
// - prescale code divides by one, two, four, eight
// - oscillator enable drives crystal power enable
// - external source: sync bit bypasses synchroniser
// - internal sources ignore the sync bit
// - wide mode: high byte latched for atomicity
// - run bit counts, clear holds value
// - go bit arms one pulse, hardware clears
// - gate source: pin, overflow, match
// - rollover to zero raises overflow flag
// - high and low bytes both read/write
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`include "gst_consts.svh"
module gst_timer
   import gst_pkg::*;
#(
   parameter int CNT_W = 16
)
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`GST_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_count_input_i,
   input wire logic gate_pin_i,
   input wire logic aux_match_i,
   output logic osc_enable_o,
   output logic overflow_o,
   output logic irq_o
);
   //*******************************
   // state
   //*******************************
   typedef struct packed {
      gst_tctrl_s tctrl;
      logic [7:0] gctrl;
      logic [CNT_W-1:0] count;
      logic [7:0] high_buf;
      logic [`GST_IRQ_W-1:0] status;
      logic [`GST_IRQ_W-1:0] mask;
      logic ovf;
      logic rd_done;
      logic [31:0] rdata;
   } gst_top_s;

   gst_top_s st_q;
   gst_top_s st_d;
   logic wr;
   logic rd;
   logic rd_wait;
   logic [11:0] idx;
   logic hit;
   logic go_set;
   logic gate_open;
   logic gate_level;
   logic go_done;
   logic done_pulse;
   logic count_en;
   logic [CNT_W:0] cnt_inc;
   logic [31:0] rd_val;
   logic [CNT_W-1:0] wcount;

   gst_tick_if tk();

   assign tk.clock_source_select = st_q.tctrl.clock_source_select;
   assign tk.prescale_select = st_q.tctrl.prescale_select;
   assign tk.ext_clock_sync_bypass = st_q.tctrl.ext_clock_sync_bypass;
   assign tk.timer_run = st_q.tctrl.timer_run;

   gst_clock_select u_clk (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .ext_clk_i(external_count_input_i),
      .tk(tk)
   );

   gst_gate_unit u_gate (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .gctrl_i(st_q.gctrl),
      .go_set_i(go_set),
      .gate_pin_i(gate_pin_i),
      .ovf_i(st_q.ovf),
      .match_i(aux_match_i),
      .gate_open_o(gate_open),
      .gate_level_o(gate_level),
      .go_done_o(go_done),
      .done_pulse_o(done_pulse)
   );

   //*******************************
   // apb decode
   //*******************************
   // printed offsets are indices; byte address is four times the index
   assign idx = paddr[`GST_ADDR_W-1:2];
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign hit = (paddr[1:0] == 2'h0) &&
      (idx == `GST_IDX_GATE_CTRL || idx == `GST_IDX_TIMER_CTRL ||
       idx == `GST_IDX_COUNT || idx == `GST_IDX_INT_STATUS ||
       idx == `GST_IDX_INT_MASK);
   // reads take one wait state so that prdata comes from a flop and
   // already stands while pready is high; writes finish at once
   assign rd_wait = rd && !st_q.rd_done;
   assign pready = !rd || st_q.rd_done;
   assign pslverr = psel && penable && !hit;
   assign prdata = st_q.rdata;
   assign go_set = wr && pstrb[0] && idx == `GST_IDX_GATE_CTRL &&
      pwdata[`GST_GC_GO];
   assign osc_enable_o = st_q.tctrl.crystal_osc_enable;
   assign overflow_o = st_q.ovf;
   assign irq_o = |(st_q.status & st_q.mask);

   //*******************************
   // next state
   //*******************************
   always_comb begin
      st_d = st_q;
      st_d.ovf = 1'b0;
      // gate only matters while gate enable is set
      count_en = tk.tick &&
         (!st_q.gctrl[`GST_GC_EN] || gate_open);
      cnt_inc = {1'b0, st_q.count} + {{CNT_W{1'b0}}, 1'b1};
      wcount = st_q.count;
      if (count_en) begin
         st_d.count = cnt_inc[CNT_W-1:0];
         if (cnt_inc[CNT_W]) begin
            st_d.ovf = 1'b1;
         end
      end
      rd_val = 32'h0;
      unique case (idx)
         `GST_IDX_TIMER_CTRL: rd_val = {24'h0, st_q.tctrl};
         `GST_IDX_GATE_CTRL: begin
            rd_val = {24'h0, st_q.gctrl};
            rd_val[`GST_GC_GO] = go_done;
            rd_val[`GST_GC_VAL] = gate_level;
         end
         `GST_IDX_COUNT: begin
            // one word read gives both bytes of one cycle, atomic in
            // either mode; the buffer keeps the high byte for a later
            // low-only write in wide mode
            rd_val = {16'h0, st_q.count[15:8], st_q.count[7:0]};
         end
         `GST_IDX_INT_STATUS: rd_val = {30'h0, st_q.status};
         `GST_IDX_INT_MASK: rd_val = {30'h0, st_q.mask};
         default: rd_val = 32'h0;
      endcase
      st_d.rd_done = rd_wait;
      if (rd_wait) begin
         st_d.rdata = hit ? rd_val : 32'h0;
         if (idx == `GST_IDX_COUNT && pstrb == 4'h0) begin
            st_d.high_buf = st_q.count[15:8];
         end
      end
      if (wr && hit) begin
         unique case (idx)
            `GST_IDX_TIMER_CTRL: begin
               if (pstrb[0]) st_d.tctrl = pwdata[7:0];
            end
            `GST_IDX_GATE_CTRL: begin
               if (pstrb[0]) st_d.gctrl = pwdata[7:0] & `GST_GC_WMASK;
            end
            `GST_IDX_COUNT: begin
               // wide mode: high byte write lands in buffer, low write
               // commits both at once; split mode writes each byte
               if (st_q.tctrl.wide_access_mode) begin
                  if (pstrb[1]) st_d.high_buf = pwdata[15:8];
                  if (pstrb[0]) begin
                     wcount[7:0] = pwdata[7:0];
                     wcount[15:8] = pstrb[1] ? pwdata[15:8] :
                        st_q.high_buf;
                     st_d.count = wcount;
                  end
               end else begin
                  if (pstrb[0]) wcount[7:0] = pwdata[7:0];
                  if (pstrb[1]) wcount[15:8] = pwdata[15:8];
                  st_d.count = wcount;
               end
            end
            `GST_IDX_INT_MASK: begin
               if (pstrb[0]) st_d.mask = pwdata[`GST_IRQ_W-1:0];
            end
            `GST_IDX_INT_STATUS: begin
               if (pstrb[0]) st_d.status = st_q.status &
                  ~pwdata[`GST_IRQ_W-1:0];
            end
            default: st_d.mask = st_q.mask;
         endcase
      end
      // set wins over the clear in the same cycle
      if (st_d.ovf) st_d.status[`GST_IRQ_OVF] = 1'b1;
      if (done_pulse) st_d.status[`GST_IRQ_GATE] = 1'b1;
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // gst_timer

/* testbench/gst_timer_properties.sv */
// port-level assertions for the gated timer top
`timescale 1ns/100ps
`include "gst_consts.svh"
module gst_timer_props #(
   parameter int CNT_W = 16
)
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`GST_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic external_count_input_i,
   input wire logic gate_pin_i,
   input wire logic aux_match_i,
   input wire logic osc_enable_o,
   input wire logic overflow_o,
   input wire logic irq_o
);
   // ****
   // shadow of software state
   // ****
   wire logic acc = psel && penable;
   wire logic [11:0] idx = paddr[13:2];
   wire logic hit = paddr[1:0] == 2'h0 && (idx == `GST_IDX_GATE_CTRL
      || idx == `GST_IDX_TIMER_CTRL || idx == `GST_IDX_COUNT
      || idx == `GST_IDX_INT_STATUS || idx == `GST_IDX_INT_MASK);
   wire logic wr0 = acc && pwrite && hit && pstrb[0];
   logic [7:0] tc_q;
   logic [1:0] mask_q;
   // idle cycles since run cleared; the tick pipeline may still drain
   logic [2:0] stop_q;
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         tc_q <= `GST_CTRL_RST;
         mask_q <= 2'h0;
         stop_q <= 3'h0;
      end else begin
         if (wr0 && idx == `GST_IDX_TIMER_CTRL) begin
            tc_q <= pwdata[7:0];
         end
         if (wr0 && idx == `GST_IDX_INT_MASK) begin
            mask_q <= pwdata[1:0];
         end
         if (tc_q[`GST_TC_RUN]) begin
            stop_q <= 3'h0;
         end else if (stop_q != 3'h7) begin
            stop_q <= stop_q + 3'h1;
         end
      end
   end
   default clocking dc @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   ready_high_a: assert property (acc && pwrite |-> pready)
      else $error("write held in wait");
   read_wait_a: assert property (acc && !pwrite && $rose(penable) |-> !pready)
      else $error("read data given no wait state");
   read_ready_a: assert property (acc && !pwrite && !pready |=> pready)
      else $error("read wait longer than one cycle");
   unmapped_err_a: assert property (acc && !hit |-> pslverr)
      else $error("no error on unmapped access");
   mapped_ok_a: assert property (acc && hit |-> !pslverr)
      else $error("error on mapped access");
   unmapped_zero_a: assert property (acc && !pwrite && !hit && pready
      |-> prdata == 32'h0) else $error("unmapped read not zero");
   ctrl_readback_a: assert property (
      acc && !pwrite && pready && hit && idx == `GST_IDX_TIMER_CTRL
      |-> prdata == {24'h0, tc_q}) else $error("control readback wrong");
   osc_follow_a: assert property (osc_enable_o == tc_q[`GST_TC_OSCEN])
      else $error("oscillator enable wrong");
   ovf_pulse_a: assert property (overflow_o |=> !overflow_o)
      else $error("overflow longer than one cycle");
   ovf_irq_a: assert property (overflow_o && mask_q[0] |-> ##[0:1] irq_o)
      else $error("overflow gave no interrupt");
   masked_quiet_a: assert property (mask_q == 2'h0 |-> !irq_o)
      else $error("interrupt while all masked");
   stopped_hold_a: assert property (stop_q > 3'h4 |-> !overflow_o)
      else $error("overflow while stopped");
   cover property (overflow_o && mask_q[0]);
   cover property (acc && !hit);
   cover property (acc && !pwrite && !pready);
   cover property (acc && !pwrite && idx == `GST_IDX_COUNT);
endmodule // gst_timer_props
bind gst_timer gst_timer_props #(.CNT_W(CNT_W)) u_gst_timer_props (
   .core_clk_i(core_clk_i), .reset_i(reset_i), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .external_count_input_i(external_count_input_i),
   .gate_pin_i(gate_pin_i), .aux_match_i(aux_match_i),
   .osc_enable_o(osc_enable_o), .overflow_o(overflow_o), .irq_o(irq_o));

/* testbench/gst_timer_tb_top.sv */
// self-checking bench for the gated timer top
`timescale 1ns/100ps
`include "gst_consts.svh"
module gst_timer_tb_top;
   typedef struct packed {
      logic [13:0] a;
      logic [7:0] w;
      logic [7:0] m;
      logic [7:0] x;
      logic e;
   } gst_row_s;
   localparam logic [13:0] a_gc = {`GST_IDX_GATE_CTRL, 2'b00};
   localparam logic [13:0] a_tc = {`GST_IDX_TIMER_CTRL, 2'b00};
   localparam logic [13:0] a_cnt = {`GST_IDX_COUNT, 2'b00};
   localparam logic [13:0] a_is = {`GST_IDX_INT_STATUS, 2'b00};
   localparam logic [13:0] a_im = {`GST_IDX_INT_MASK, 2'b00};
   localparam logic [13:0] regs [5] = '{a_gc, a_tc, a_cnt, a_is, a_im};
   // bit 2 of gate control is read-only, hence the FB masks
   localparam gst_row_s rows [6] = '{
      '{a_tc, 8'h7C, 8'hFF, 8'h7C, 1'b0},
      '{a_tc + 14'h2, 8'h55, 8'hFF, 8'h00, 1'b1},
      '{a_gc, 8'hE1, 8'hFB, 8'hE1, 1'b0},
      '{a_gc, 8'h00, 8'hFB, 8'h00, 1'b0},
      '{a_im, 8'h03, 8'hFF, 8'h03, 1'b0},
      '{14'h3000, 8'hAA, 8'hFF, 8'h00, 1'b1}};
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [13:0] paddr = 14'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic ext_i = 1'b0;
   logic gpin = 1'b0;
   logic amatch = 1'b0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic [31:0] v;
   logic pready, pslverr, osc_o, ovf_o, irq_o, err, act;
   int errors = 0;
   int checked = 0;
   int n, base, e, t;
   always #5 core_clk_i = ~core_clk_i;
   gst_timer #(.CNT_W(16)) u_gst_timer (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_count_input_i(ext_i), .gate_pin_i(gpin),
      .aux_match_i(amatch), .osc_enable_o(osc_o), .overflow_o(ovf_o),
      .irq_o(irq_o));
   // ****
   // bus, compare and report tasks
   // ****
   task automatic close_out();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
      checked++;
      if ($isunknown(got) || got < lo || got > hi) begin
         errors++;
         $display("Error at %0t: got %h range %h %h", $time, got, lo, hi);
      end
   endtask
   task automatic fin(input string s);
      $display("test %s done", s);
   endtask
   task automatic bus(input logic w, input logic [13:0] a,
      input logic [31:0] d, input logic [3:0] s);
      int k;
      @(posedge core_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk_i);
      penable <= 1'b1;
      // look at settled values; the next edge then completes the access
      #1;
      k = 0;
      while (pready !== 1'b1 && k < 16) begin
         @(posedge core_clk_i);
         #1;
         k++;
      end
      if (k >= 16) begin
         errors++;
         close_out();
      end
      err = pslverr;
      rd = prdata;
      @(posedge core_clk_i);
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   // gate control goes in before timer control
   task automatic run_for(input logic [7:0] gc, input logic [7:0] tc,
      input int cyc);
      ext_i <= 1'b0;
      bus(1'b1, a_gc, {24'h0, gc}, 4'h1);
      bus(1'b1, a_cnt, 32'h0, 4'h3);
      bus(1'b1, a_tc, {24'h0, tc}, 4'h1);
      for (int k = 0; k < cyc; k++) begin
         @(posedge core_clk_i);
         if (k % 4 == 3 && k < cyc - 8) begin
            ext_i <= ~ext_i;
         end
      end
      bus(1'b1, a_tc, 32'h0, 4'h1);
      bus(1'b0, a_cnt, 32'h0, 4'h0);
   endtask
   initial begin
      repeat (3) @(posedge core_clk_i);
      reset_i <= 1'b0;
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, {24'h0, rows[i].w}, 4'h1);
         chk({31'h0, err}, {31'h0, rows[i].e});
         bus(1'b0, rows[i].a, 32'h0, 4'h0);
         chk(rd & {24'h0, rows[i].m}, {24'h0, rows[i].x});
      end
      fin("registers");
      // external input toggles in every run: 9 rising edges
      // no capture unit listens here, so system clock is fair
      for (int c = 0; c < 3; c++) begin
         for (int p = 0; p < 4; p++) begin
            run_for(8'h00, {c[1:0], p[1:0], 1'b1, p[0], 2'b01}, 80);
            base = (c == 2) ? 9 : ((c == 0) ? 20 : 82);
            e = base >> p;
            t = (c == 2) ? ((p == 0) ? 0 : 1) : 2;
            chk_rng(rd, (e > t) ? e - t : 0, e + t);
         end
      end
      v = rd;
      repeat (8) @(posedge core_clk_i);
      bus(1'b0, a_cnt, 32'h0, 4'h0);
      chk(rd, v);
      fin("clock and prescale");
      for (int g = 0; g < 3; g++) begin
         for (int l = 0; l < 4; l++) begin
            gpin <= (g == 0) ? l[0] : ~l[0];
            amatch <= (g == 2) ? l[0] : ~l[0];
            act = ((g == 1) ? 1'b0 : l[0]) == l[1];
            run_for({1'b1, l[1], 4'h0, g[1:0]}, 8'h41, 30);
            chk_rng(rd, act ? 30 : 0, act ? 34 : 0);
         end
      end
      gpin <= 1'b0;
      bus(1'b1, a_gc, 32'hD0, 4'h1);
      bus(1'b1, a_gc, 32'hD8, 4'h1);
      bus(1'b0, a_gc, 32'h0, 4'h0);
      chk(rd & 32'h8, 32'h8);
      gpin <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      gpin <= 1'b0;
      repeat (6) @(posedge core_clk_i);
      bus(1'b0, a_gc, 32'h0, 4'h0);
      chk(rd & 32'h8, 32'h0);
      bus(1'b0, a_is, 32'h0, 4'h0);
      chk(rd & 32'h2, 32'h2);
      bus(1'b1, a_gc, 32'hD8, 4'h1);
      bus(1'b1, a_gc, 32'hC8, 4'h1);
      bus(1'b0, a_gc, 32'h0, 4'h0);
      chk(rd & 32'h8, 32'h0);
      fin("gate");
      bus(1'b1, a_gc, 32'h0, 4'h1);
      bus(1'b1, a_is, 32'h3, 4'h1);
      bus(1'b1, a_im, 32'h1, 4'h1);
      bus(1'b1, a_cnt, 32'hFFF0, 4'h3);
      bus(1'b1, a_tc, 32'h41, 4'h1);
      n = 0;
      while (ovf_o !== 1'b1) begin
         @(posedge core_clk_i);
         #1;
         n++;
         if (n > 64) begin
            errors++;
            close_out();
         end
      end
      chk({31'h0, irq_o}, 32'h1);
      bus(1'b1, a_tc, 32'h0, 4'h1);
      bus(1'b0, a_is, 32'h0, 4'h0);
      chk(rd & 32'h1, 32'h1);
      bus(1'b1, a_im, 32'h0, 4'h1);
      chk({31'h0, irq_o}, 32'h0);
      bus(1'b1, a_im, 32'h1, 4'h1);
      chk({31'h0, irq_o}, 32'h1);
      bus(1'b1, a_is, 32'h1, 4'h1);
      chk({31'h0, irq_o}, 32'h0);
      fin("overflow");
      bus(1'b1, a_cnt, 32'h1234, 4'h3);
      bus(1'b1, a_cnt, 32'h7700, 4'h2);
      bus(1'b0, a_cnt, 32'h0, 4'h0);
      chk(rd, 32'h7734);
      bus(1'b1, a_tc, 32'h2, 4'h1);
      bus(1'b1, a_cnt, 32'h5500, 4'h2);
      bus(1'b1, a_cnt, 32'h0066, 4'h1);
      bus(1'b0, a_cnt, 32'h0, 4'h0);
      chk(rd, 32'h5566);
      fin("count access");
      // toggle mode: each rising gate edge flips the gate flip-flop
      gpin <= 1'b0;
      bus(1'b1, a_gc, 32'hE0, 4'h1);
      bus(1'b1, a_cnt, 32'h0, 4'h3);
      bus(1'b1, a_tc, 32'h41, 4'h1);
      @(posedge core_clk_i);
      gpin <= 1'b1;
      @(posedge core_clk_i);
      gpin <= 1'b0;
      repeat (20) @(posedge core_clk_i);
      gpin <= 1'b1;
      @(posedge core_clk_i);
      gpin <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      bus(1'b0, a_cnt, 32'h0, 4'h0);
      chk(rd, 32'h15);
      bus(1'b1, a_tc, 32'h0, 4'h1);
      fin("toggle");
      bus(1'b1, a_tc, 32'h8, 4'h1);
      bus(1'b1, a_im, 32'h3, 4'h1);
      reset_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      reset_i <= 1'b0;
      #1;
      chk({30'h0, osc_o, irq_o}, 32'h0);
      foreach (regs[i]) begin
         bus(1'b0, regs[i], 32'h0, 4'h0);
         chk(rd & 32'hFFFB, 32'h0);
      end
      fin("reset");
      close_out();
   end
endmodule // gst_timer_tb_top
